/* pmrp_cfg.svh */
// Purpose: constants of the program memory read port
// Assumes: included by its bare name wherever a constant is needed
// Notes: offsets are register indices; the byte address is four times the index
`ifndef PMRP_CFG_SVH
`define PMRP_CFG_SVH

// register indices
`define PMRP_IDX_DATA_LOW 12'h10c
`define PMRP_IDX_ADDR_LOW 12'h10d
`define PMRP_IDX_DATA_HIGH 12'h10e
`define PMRP_IDX_ADDR_HIGH 12'h10f
`define PMRP_IDX_CONTROL 12'h18c

// field positions and widths
`define PMRP_CTRL_TRIG_BIT 0
`define PMRP_CTRL_RSVD_BIT 7
`define PMRP_DATA_HIGH_W 6
`define PMRP_ADDR_HIGH_W 5
`define PMRP_WORD_W 14
`define PMRP_ADDR_W 13
`define PMRP_FLASH_AW 11

// reset values
`define PMRP_RST_DATA 8'h00
`define PMRP_RST_ADDR 8'h00
`define PMRP_RST_ADDR_HI 5'h00
`define PMRP_RST_DATA_HI 6'h00
`define PMRP_RST_TRIG 1'b0
`define PMRP_CTRL_FIXED 8'h80

// timing: one instruction cycle, in ns, and the clock rate in MHz
`define PMRP_INSTR_CYCLE_NS 200
`define PMRP_CLK_MHZ 20
`define PMRP_CYC_CLKS ((`PMRP_INSTR_CYCLE_NS * `PMRP_CLK_MHZ) / 1000)

// AXI responses
`define PMRP_RESP_OKAY 2'b00
`define PMRP_RESP_SLVERR 2'b10

`endif

/* pmrp_pkg.sv */
// Purpose: types of the program memory read port
// Assumes: nothing
// Notes: states are gray coded along the read sequence
package pmrp_pkg;

    typedef enum logic [1:0] {
        PMRP_IDLE = 2'b00,
        PMRP_ARMED = 2'b01,
        PMRP_WAIT = 2'b11,
        PMRP_FETCH = 2'b10
    } pmrp_state_e;

    typedef logic [1:0] pmrp_resp_t;

endpackage : pmrp_pkg

/* pmrp_cycle_timer.sv */
// Purpose: instruction cycle enable from the system clock
// Assumes: CLKS of at least two
// Notes: cycEn is high for the last clock of each instruction cycle
`timescale 1ns/100ps
`default_nettype none

module pmrp_cycle_timer #(
    parameter int unsigned CLKS = 4
) (
    input wire logic clk,
    input wire logic srst,
    output logic cycEn
);

    localparam int unsigned CW = (CLKS > 1) ? $clog2(CLKS) : 1;

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    wire logic lastClk;

    assign lastClk = (cnt_r == CW'(CLKS - 1));
    assign cnt_nxt = lastClk ? '0 : cnt_r + CW'(1);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cnt_r <= '0;
            cycEn <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            cycEn <= (cnt_nxt == CW'(CLKS - 1));
        end
    end

endmodule : pmrp_cycle_timer

`default_nettype wire

/* pmrp_top.sv */
// Purpose: program memory read port behind an AXI4-Lite register slave
// Assumes: flash array answers flashData one clock after flashRdEn
// Notes: one instruction cycle is CYC_CLKS clocks
`timescale 1ns/100ps
`default_nettype none
`include "pmrp_cfg.svh"

module pmrp_top #(
    parameter int unsigned AXI_AW = 12,
    parameter int unsigned CYC_CLKS = `PMRP_CYC_CLKS
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [`PMRP_FLASH_AW-1:0] flashAddr,
    output logic flashRdEn,
    input wire logic [`PMRP_WORD_W-1:0] flashData,
    output logic instrSuppress,
    output logic readBusy
);

    logic [7:0] dataLow_r;
    logic [`PMRP_DATA_HIGH_W-1:0] dataHigh_r;
    logic [7:0] addrLow_r;
    logic [`PMRP_ADDR_HIGH_W-1:0] addrHigh_r;
    logic trig_r;
    pmrp_pkg::pmrp_state_e state_r;
    pmrp_pkg::pmrp_state_e state_nxt;
    logic capture_r;

    logic awHeld_r;
    logic [AXI_AW-1:0] awAddr_r;
    logic wHeld_r;
    logic [7:0] wByte_r;
    logic wLane0_r;
    logic bvalid_r;
    pmrp_pkg::pmrp_resp_t bresp_r;

    logic rvalid_r;
    logic [31:0] rdata_r;
    pmrp_pkg::pmrp_resp_t rresp_r;

    wire logic cycEn;

    function automatic logic hitIdx(input logic [AXI_AW-1:0] addr, input logic [11:0] idx);
        logic [AXI_AW+1:0] byteAddr;
        byteAddr = {idx, 2'b00};
        hitIdx = (addr == byteAddr[AXI_AW-1:0]);
    endfunction : hitIdx

    function automatic logic isMapped(input logic [AXI_AW-1:0] addr);
        isMapped = hitIdx(addr, `PMRP_IDX_DATA_LOW) || hitIdx(addr, `PMRP_IDX_DATA_HIGH)
            || hitIdx(addr, `PMRP_IDX_ADDR_LOW) || hitIdx(addr, `PMRP_IDX_ADDR_HIGH)
            || hitIdx(addr, `PMRP_IDX_CONTROL);
    endfunction : isMapped

    pmrp_cycle_timer #(
        .CLKS(CYC_CLKS)
    ) u_cycle_timer (
        .clk(clk),
        .srst(srst),
        .cycEn(cycEn)
    );

    // write path
    wire logic doWrite;
    wire logic wrOk;
    wire logic wrDataLow;
    wire logic wrDataHigh;
    wire logic wrAddrLow;
    wire logic wrAddrHigh;
    wire logic wrCtrl;
    wire logic trigSet;
    wire logic trigClr;
    wire logic fetchStart;
    wire logic [`PMRP_ADDR_W-1:0] fullAddr;

    assign s_axi_awready = !awHeld_r && !bvalid_r;
    assign s_axi_wready = !wHeld_r && !bvalid_r;
    assign doWrite = awHeld_r && wHeld_r && !bvalid_r;
    assign wrOk = doWrite && wLane0_r;
    assign wrDataLow = wrOk && hitIdx(awAddr_r, `PMRP_IDX_DATA_LOW);
    assign wrDataHigh = wrOk && hitIdx(awAddr_r, `PMRP_IDX_DATA_HIGH);
    assign wrAddrLow = wrOk && hitIdx(awAddr_r, `PMRP_IDX_ADDR_LOW);
    assign wrAddrHigh = wrOk && hitIdx(awAddr_r, `PMRP_IDX_ADDR_HIGH);
    assign wrCtrl = wrOk && hitIdx(awAddr_r, `PMRP_IDX_CONTROL);
    // writing one starts a read; zero has no effect; ignored while busy
    assign trigSet = wrCtrl && wByte_r[`PMRP_CTRL_TRIG_BIT] && (state_r == pmrp_pkg::PMRP_IDLE);
    assign trigClr = (state_r == pmrp_pkg::PMRP_FETCH) && cycEn;
    assign fetchStart = (state_r == pmrp_pkg::PMRP_WAIT) && cycEn;
    // full 13-bit address; only the low 11 bits reach the fitted 2K array
    assign fullAddr = {addrHigh_r, addrLow_r};

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            awHeld_r <= 1'b0;
            awAddr_r <= '0;
            wHeld_r <= 1'b0;
            wByte_r <= 8'h00;
            wLane0_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `PMRP_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            else if (doWrite)
            begin
                awHeld_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_r <= 1'b1;
                wByte_r <= s_axi_wdata[7:0];
                wLane0_r <= s_axi_wstrb[0];
            end
            else if (doWrite)
            begin
                wHeld_r <= 1'b0;
            end
            if (doWrite)
            begin
                bvalid_r <= 1'b1;
                bresp_r <= isMapped(awAddr_r) ? `PMRP_RESP_OKAY : `PMRP_RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                bvalid_r <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // read path
    wire logic arTake;
    wire logic [7:0] ctrlView;
    wire logic [7:0] dataHighView;
    wire logic [7:0] addrHighView;
    wire logic [7:0] readByte;

    assign arTake = s_axi_arvalid && s_axi_arready;
    assign s_axi_arready = !rvalid_r;
    assign ctrlView = `PMRP_CTRL_FIXED | {7'h00, trig_r};
    assign dataHighView = {2'b00, dataHigh_r};
    assign addrHighView = {3'b000, addrHigh_r};
    assign readByte = hitIdx(s_axi_araddr, `PMRP_IDX_DATA_LOW) ? dataLow_r
        : hitIdx(s_axi_araddr, `PMRP_IDX_DATA_HIGH) ? dataHighView
        : hitIdx(s_axi_araddr, `PMRP_IDX_ADDR_LOW) ? addrLow_r
        : hitIdx(s_axi_araddr, `PMRP_IDX_ADDR_HIGH) ? addrHighView
        : hitIdx(s_axi_araddr, `PMRP_IDX_CONTROL) ? ctrlView
        : 8'h00;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `PMRP_RESP_OKAY;
        end
        else if (arTake)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h000000, readByte};
            rresp_r <= isMapped(s_axi_araddr) ? `PMRP_RESP_OKAY : `PMRP_RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // read sequencer: armed for rest of current cycle, one normal cycle, then fetch
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            pmrp_pkg::PMRP_IDLE:
            begin
                if (trigSet)
                begin
                    state_nxt = pmrp_pkg::PMRP_ARMED;
                end
            end
            pmrp_pkg::PMRP_ARMED:
            begin
                if (cycEn)
                begin
                    state_nxt = pmrp_pkg::PMRP_WAIT;
                end
            end
            pmrp_pkg::PMRP_WAIT:
            begin
                if (cycEn)
                begin
                    state_nxt = pmrp_pkg::PMRP_FETCH;
                end
            end
            pmrp_pkg::PMRP_FETCH:
            begin
                if (cycEn)
                begin
                    state_nxt = pmrp_pkg::PMRP_IDLE;
                end
            end
            default:
            begin
                state_nxt = pmrp_pkg::PMRP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_r <= pmrp_pkg::PMRP_IDLE;
            trig_r <= `PMRP_RST_TRIG;
        end
        else
        begin
            state_r <= state_nxt;
            if (trigSet)
            begin
                trig_r <= 1'b1;
            end
            else if (trigClr)
            begin
                trig_r <= 1'b0;
            end
        end
    end

    // flash access; no protection gating, any location is readable
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            flashRdEn <= 1'b0;
            flashAddr <= '0;
            capture_r <= 1'b0;
        end
        else
        begin
            flashRdEn <= fetchStart;
            capture_r <= flashRdEn;
            if (fetchStart)
            begin
                flashAddr <= fullAddr[`PMRP_FLASH_AW-1:0];
            end
        end
    end

    // address pair, software owned
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            addrLow_r <= `PMRP_RST_ADDR;
            addrHigh_r <= `PMRP_RST_ADDR_HI;
        end
        else
        begin
            if (wrAddrLow)
            begin
                addrLow_r <= wByte_r;
            end
            if (wrAddrHigh)
            begin
                addrHigh_r <= wByte_r[`PMRP_ADDR_HIGH_W-1:0];
            end
        end
    end

    // data pair: whole word lands at once; a completing read beats software
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            dataLow_r <= `PMRP_RST_DATA;
            dataHigh_r <= `PMRP_RST_DATA_HI;
        end
        else if (capture_r)
        begin
            dataLow_r <= flashData[7:0];
            dataHigh_r <= flashData[`PMRP_WORD_W-1:8];
        end
        else
        begin
            if (wrDataLow)
            begin
                dataLow_r <= wByte_r;
            end
            if (wrDataHigh)
            begin
                dataHigh_r <= wByte_r[`PMRP_DATA_HIGH_W-1:0];
            end
        end
    end

    assign instrSuppress = (state_r == pmrp_pkg::PMRP_FETCH);
    assign readBusy = trig_r;

endmodule : pmrp_top

`default_nettype wire

/* pmrp_properties.sv */
// Purpose: timing checks of the program memory read port
// Assumes: ports of pmrp_top
// Notes: bound at the foot
`timescale 1ns/100ps
`default_nettype none
`include "pmrp_cfg.svh"
module pmrp_properties #(
    parameter int unsigned CYC_CLKS = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [`PMRP_FLASH_AW-1:0] flashAddr,
    input wire logic flashRdEn,
    input wire logic instrSuppress,
    input wire logic readBusy
);
    localparam int DMIN = CYC_CLKS + 1;
    localparam int DMAX = 2 * CYC_CLKS;
    logic [7:0] supCnt;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // length of the current suppressed cycle
    always_ff @(posedge clk)
    begin
        supCnt <= (srst || !instrSuppress) ? 8'h00 : supCnt + 8'h01;
    end
    sequence fetch_start_s;
        $rose(instrSuppress);
    endsequence
    sequence rd_pulse_s;
        flashRdEn ##1 !flashRdEn;
    endsequence
    trig_set_a: assert property ($rose(readBusy) |-> $rose(s_axi_bvalid))
        else $error("trigger set without a write answer");
    rd_pulse_a: assert property (flashRdEn |-> rd_pulse_s)
        else $error("flash read strobe longer than one clock");
    fetch_pulse_a: assert property (fetch_start_s |-> flashRdEn)
        else $error("fetch cycle without flash read");
    suppress_len_a: assert property ($fell(instrSuppress) |-> supCnt == 8'(CYC_CLKS))
        else $error("suppressed cycle of wrong length");
    busy_clear_a: assert property ($fell(readBusy) |-> $fell(instrSuppress))
        else $error("trigger cleared outside end of fetch");
    reset_idle_a: assert property ($past(srst) |-> !readBusy && !flashRdEn)
        else $error("read pending after reset");
    addr_hold_a: assert property (instrSuppress && $past(instrSuppress) |-> $stable(flashAddr))
        else $error("flash address moved during fetch");
    fetch_delay_a: assert property ($rose(readBusy) |-> ##[DMIN:DMAX] fetch_start_s)
        else $error("fetch not in second instruction cycle");
    rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
endmodule : pmrp_properties
bind pmrp_top pmrp_properties #(.CYC_CLKS(CYC_CLKS)) i_props (
    .clk(clk), .srst(srst), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
    .flashAddr(flashAddr), .flashRdEn(flashRdEn),
    .instrSuppress(instrSuppress), .readBusy(readBusy)
);
`default_nettype wire

/* pmrp_testbench.sv */
// Purpose: self-checking bench of the program memory read port
// Assumes: AXI4-Lite master driven from here
// Notes: flash array modelled inline, one clock of latency
`timescale 1ns/100ps
`default_nettype none
`include "pmrp_cfg.svh"
module testbench;
    localparam int unsigned CYC = 6;
    localparam logic [11:0] A_DL = 12'h430;
    localparam logic [11:0] A_AL = 12'h434;
    localparam logic [11:0] A_DH = 12'h438;
    localparam logic [11:0] A_AH = 12'h43c;
    localparam logic [11:0] A_CT = 12'h630;
    logic clk, srst, awValid, awReady, wValid, wReady, bValid, bReady;
    logic arValid, arReady, rValid, rReady, flashRdEn, instrSuppress, readBusy;
    logic [11:0] awAddr, arAddr;
    logic [31:0] wData, rData;
    logic [3:0] wStrb;
    logic [1:0] bResp, rResp, lastResp;
    logic [10:0] flashAddr, seenAddr;
    logic [13:0] flashData;
    int err_count = 0;
    int checks_done = 0;
    int supRun = 0;
    int supLast = 0;
    pmrp_top #(.AXI_AW(12), .CYC_CLKS(CYC)) i_dut (
        .clk(clk), .srst(srst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .flashAddr(flashAddr), .flashRdEn(flashRdEn), .flashData(flashData),
        .instrSuppress(instrSuppress), .readBusy(readBusy)
    );
    function automatic logic [13:0] flash_word(input logic [10:0] a);
        return {3'h5, a} ^ 14'h2a5c;
    endfunction : flash_word
    function automatic logic [33:0] ok(input logic [7:0] d);
        return {26'h0, d};
    endfunction : ok
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // flash answers a clock after the strobe, otherwise keeps toggling
    always @(posedge clk)
    begin
        if (srst)
            flashData <= 14'h0000;
        else if (flashRdEn)
        begin
            flashData <= flash_word(flashAddr);
            seenAddr <= flashAddr;
        end
        else
            flashData <= ~flashData;
    end
    // length of the last suppressed run, counted at falling edges
    always @(negedge clk)
    begin
        if (instrSuppress === 1'b1)
            supRun <= supRun + 1;
        else
            supRun <= 0;
        if (instrSuppress !== 1'b1 && supRun != 0)
            supLast <= supRun;
    end
    task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
        checks_done++;
        if (s !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic aw, w, b;
        @(posedge clk);
        awAddr <= a;
        wData <= {24'h0, d};
        wStrb <= 4'h1;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        do
        begin
            @(negedge clk);
            aw = awValid && awReady;
            w = wValid && wReady;
            b = bValid;
            lastResp = bResp;
            @(posedge clk);
            if (aw)
                awValid <= 1'b0;
            if (w)
                wValid <= 1'b0;
        end
        while (!b);
        bReady <= 1'b0;
    endtask : wr
    task automatic rdc(input string n, input logic [11:0] a, input logic [33:0] e);
        logic ar, r;
        logic [33:0] v;
        @(posedge clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do
        begin
            @(negedge clk);
            ar = arValid && arReady;
            r = rValid;
            v = {rResp, rData};
            @(posedge clk);
            if (ar)
                arValid <= 1'b0;
        end
        while (!r);
        rReady <= 1'b0;
        chk(n, v, e);
    endtask : rdc
    task automatic t_reset;
        chk("busy", {33'h0, readBusy}, 34'h0);
        rdc("control", A_CT, ok(8'h80));
        for (int i = 0; i < 4; i++)
            rdc("word reg", A_DL + 12'(4 * i), ok(8'h00));
    endtask : t_reset
    task automatic t_regs;
        wr(A_AH, 8'hff);
        rdc("addr high", A_AH, ok(8'h1f));
        wr(A_DH, 8'hff);
        rdc("data high", A_DH, ok(8'h3f));
        wr(A_AL, 8'ha5);
        rdc("addr low", A_AL, ok(8'ha5));
        wr(A_DL, 8'h5a);
        rdc("data low", A_DL, ok(8'h5a));
        wr(A_CT, 8'h7e);
        rdc("ctrl no start", A_CT, ok(8'h80));
        chk("idle", {33'h0, readBusy}, 34'h0);
        wr(12'h000, 8'h11);
        chk("bad wr", {32'h0, lastResp}, 34'h2);
        rdc("bad rd", 12'h004, {2'b10, 32'h0});
    endtask : t_regs
    task automatic t_fetch;
        logic [12:0] adr[3] = '{13'h07ff, 13'h0000, 13'h1abc};
        logic [13:0] word;
        foreach (adr[i])
        begin
            word = flash_word(adr[i][10:0]);
            wr(A_AH, {3'h0, adr[i][12:8]});
            wr(A_AL, adr[i][7:0]);
            wr(A_CT, 8'h01);
            chk("busy set", {33'h0, readBusy}, 34'h1);
            wr(A_CT, 8'h00);
            rdc("ctrl busy", A_CT, ok(8'h81));
            while (readBusy !== 1'b0)
                @(posedge clk);
            chk("flash addr", {23'h0, seenAddr}, {23'h0, adr[i][10:0]});
            chk("suppress len", 34'(supLast), 34'(CYC));
            wr(A_AL, ~adr[i][7:0]);
            rdc("word low", A_DL, ok(word[7:0]));
            rdc("word high", A_DH, ok({2'b00, word[13:8]}));
        end
    endtask : t_fetch
    task automatic t_midreset;
        int bad = 0;
        wr(A_CT, 8'h01);
        chk("busy pre reset", {33'h0, readBusy}, 34'h1);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        repeat (3 * CYC)
        begin
            @(negedge clk);
            if (flashRdEn !== 1'b0 || instrSuppress !== 1'b0 || readBusy !== 1'b0)
                bad++;
        end
        chk("no read after reset", 34'(bad), 34'h0);
        rdc("ctrl after reset", A_CT, ok(8'h80));
    endtask : t_midreset
    task automatic print_verdict;
        if (err_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    initial
    begin
        srst = 1'b1;
        {awValid, wValid, bReady, arValid, rReady} = 5'h00;
        {awAddr, arAddr, wData, wStrb} = '0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_regs;
        t_fetch;
        t_midreset;
        print_verdict;
    end
    initial
    begin
        repeat (4000) @(posedge clk);
        err_count++;
        print_verdict;
    end
endmodule : testbench
`default_nettype wire
